// >>> hdl/iplt_pkg.sv
// Constants, register map and carrier types of the idle parking light timer
package iplt_pkg;
	// Register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PARK_DELAY = 8'h04;
	localparam logic [7:0] REG_PARK_FLOOR = 8'h08;
	localparam logic [7:0] REG_PARK_OFFS = 8'h0c;
	localparam logic [7:0] REG_LIGHT_DELAY = 8'h10;
	localparam logic [7:0] REG_ZONE = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;

	// Field positions
	localparam int CTRL_STRAT_LSB = 0;
	localparam int CTRL_SWING_BIT = 2;
	localparam int ZONE_TEAM_LSB = 0;
	localparam int ZONE_LOBBY_CARS_LSB = 4;
	localparam int ZONE_INDEX_LSB = 8;
	localparam int ZONE_FLOORS_LSB = 12;
	localparam int ZONE_LOBBY_FLOOR_LSB = 20;
	localparam int STAT_IDLE_BIT = 0;
	localparam int STAT_PARKED_BIT = 1;
	localparam int STAT_LIGHT_OFF_BIT = 2;
	localparam int STAT_TRIP_BIT = 3;
	localparam int STAT_DEST_LSB = 8;

	// Reset values
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [15:0] PARK_DELAY_RST = 16'h003c;
	localparam logic [7:0] PARK_FLOOR_RST = 8'hff;
	localparam logic [15:0] PARK_OFFS_RST = 16'h0000;
	localparam logic [15:0] LIGHT_DELAY_RST = 16'h00b4;
	localparam logic [27:0] ZONE_RST = 28'h0000000;

	// Parking floor value meaning "off"
	localparam logic [7:0] FLOOR_OFF = 8'hff;

	// Timing: delays count in whole seconds
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_S = 1;
	localparam int SEC_CYCLES = CLK_HZ * TICK_S;
	localparam int STANDBY_MAX_S = 3;

	typedef enum logic [1:0] {
		STRAT_SIMPLE = 2'h0,
		STRAT_ZONE = 2'h1,
		STRAT_LEARN = 2'h2
	} iplt_strat_t;

	typedef enum logic [2:0] {
		P_WAIT = 3'b001,
		P_TRIP = 3'b010,
		P_PARKED = 3'b100
	} iplt_park_st_t;

	typedef enum logic [2:0] {
		A_IDLE = 3'b001,
		A_CAR = 3'b010,
		A_SHAFT = 3'b100
	} iplt_ack_st_t;

	// Lift state from the controller
	typedef struct packed {
		logic calls_pending;
		logic car_pref;
		logic maintenance;
		logic guest_pending;
		logic prio_pending;
		logic load_hold;
		logic special_op;
		logic standby;
		logic car_doors_closed;
		logic landing_doors_closed;
	} iplt_status_t;

	// Trip command to the drive sequencing
	typedef struct packed {
		logic [7:0] floor;
		logic signed [15:0] offset_mm;
	} iplt_trip_t;

	// Parking acknowledge message for the field bus
	typedef struct packed {
		logic to_shaft;
		logic [7:0] floor;
	} iplt_ack_t;
endpackage

// >>> hdl/iplt_top.sv
// Idle supervision, parking and cabin light-off timer
//
// Operation
// - Simple mode parks at the set floor after idle plus parking delay.
// - Idle means no calls, no car preference and doors closed.
// - Swing doors count as closed when the landing doors are closed.
// - Parking floor off still parks, staying at the current floor.
// - Strategy selects simple, zone or self-learning destination.
// - Zone mode places each team car in the middle of its zone.
// - Cars reserved at the lobby reduce the cars covering zones.
// - Between-floor offset applies in simple mode only.
// - Self-learning picks the majority-vote floor of demands in this week slot.
// - Parking is inhibited by preference, maintenance, guest, priority, hold.
// - When parked, acknowledge goes out twice: car then shaft.
// - Cabin light goes off after doors closed and light delay idle.
// - Light-off door condition follows the same door type rule.
// - Standby switches the cabin light off at once.
// - Light stays on under preference, guest, priority or special ops; the code lets standby switch it off even then.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module iplt_top #(
	parameter int TICK_CYCLES = iplt_pkg::SEC_CYCLES,
	parameter int SLOTS = 168
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input iplt_pkg::iplt_status_t lift_stat,
	input wire logic [7:0] cur_floor,
	input wire logic [7:0] week_slot,
	input wire logic demand_stb,
	input wire logic [7:0] demand_floor,
	input wire logic arrived,
	output logic trip_req,
	output iplt_pkg::iplt_trip_t trip,
	output logic ack_valid,
	input wire logic ack_ready,
	output iplt_pkg::iplt_ack_t ack,
	output logic light_off,
	output logic parked
);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
	localparam int SW = $clog2(SLOTS);

	logic [2:0] ctrl_r, ctrl_nxt;
	logic [15:0] park_delay_r, park_delay_nxt;
	logic [7:0] park_floor_cfg_r, park_floor_cfg_nxt;
	logic [15:0] park_offs_r, park_offs_nxt;
	logic [15:0] light_delay_r, light_delay_nxt;
	logic [27:0] zone_r, zone_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
	logic tick;
	logic [15:0] park_cnt_r, park_cnt_nxt;
	logic [15:0] light_cnt_r, light_cnt_nxt;
	iplt_pkg::iplt_park_st_t park_st_r, park_st_nxt;
	iplt_pkg::iplt_ack_st_t ack_st_r, ack_st_nxt;
	logic [7:0] dest_r, dest_nxt;
	logic trip_req_r, trip_req_nxt;
	logic light_off_r, light_off_nxt;
	logic [7:0] lrn_cand [SLOTS];
	logic [3:0] lrn_cnt [SLOTS];
	logic lrn_we;
	logic [SW-1:0] lrn_idx;
	logic [7:0] lrn_cand_nxt;
	logic [3:0] lrn_cnt_nxt;
	logic [SW-1:0] slot;
	logic slot_ok;
	logic swing, doors_ok, idle, park_inh, light_hold;
	iplt_pkg::iplt_strat_t strat;
	logic [3:0] team, lobby_cars, my_idx, zones, zk;
	logic [7:0] floors, lobby_floor, zone_dest, dest_sel;
	logic [12:0] zone_num;
	logic [4:0] zone_den;
	logic dest_off, park_due;

	// Register writes
	always_comb begin
		ctrl_nxt = ctrl_r;
		park_delay_nxt = park_delay_r;
		park_floor_cfg_nxt = park_floor_cfg_r;
		park_offs_nxt = park_offs_r;
		light_delay_nxt = light_delay_r;
		zone_nxt = zone_r;
		if (reg_wr) begin
			unique case (reg_addr)
				iplt_pkg::REG_CTRL: ctrl_nxt = reg_wdata[2:0];
				iplt_pkg::REG_PARK_DELAY: park_delay_nxt = reg_wdata[15:0];
				iplt_pkg::REG_PARK_FLOOR: park_floor_cfg_nxt = reg_wdata[7:0];
				iplt_pkg::REG_PARK_OFFS: park_offs_nxt = reg_wdata[15:0];
				iplt_pkg::REG_LIGHT_DELAY: light_delay_nxt = reg_wdata[15:0];
				iplt_pkg::REG_ZONE: zone_nxt = reg_wdata[27:0];
				default: ;
			endcase
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rdata_nxt = 32'h00000000;
		if (reg_rd) begin
			unique case (reg_addr)
				iplt_pkg::REG_CTRL: rdata_nxt = {29'h0, ctrl_r};
				iplt_pkg::REG_PARK_DELAY: rdata_nxt = {16'h0, park_delay_r};
				iplt_pkg::REG_PARK_FLOOR: rdata_nxt = {24'h0, park_floor_cfg_r};
				iplt_pkg::REG_PARK_OFFS: rdata_nxt = {16'h0, park_offs_r};
				iplt_pkg::REG_LIGHT_DELAY: rdata_nxt = {16'h0, light_delay_r};
				iplt_pkg::REG_ZONE: rdata_nxt = {4'h0, zone_r};
				iplt_pkg::REG_STATUS: begin
					rdata_nxt[iplt_pkg::STAT_IDLE_BIT] = idle;
					rdata_nxt[iplt_pkg::STAT_PARKED_BIT] =
						(park_st_r == iplt_pkg::P_PARKED);
					rdata_nxt[iplt_pkg::STAT_LIGHT_OFF_BIT] = light_off_r;
					rdata_nxt[iplt_pkg::STAT_TRIP_BIT] =
						(park_st_r == iplt_pkg::P_TRIP);
					rdata_nxt[iplt_pkg::STAT_DEST_LSB +: 8] = dest_r;
				end
				default: ;
			endcase
		end
	end

	// Configuration fields
	assign strat = iplt_pkg::iplt_strat_t'(ctrl_r[iplt_pkg::CTRL_STRAT_LSB +: 2]);
	assign swing = ctrl_r[iplt_pkg::CTRL_SWING_BIT];
	assign team = zone_r[iplt_pkg::ZONE_TEAM_LSB +: 4];
	assign lobby_cars = zone_r[iplt_pkg::ZONE_LOBBY_CARS_LSB +: 4];
	assign my_idx = zone_r[iplt_pkg::ZONE_INDEX_LSB +: 4];
	assign floors = zone_r[iplt_pkg::ZONE_FLOORS_LSB +: 8];
	assign lobby_floor = zone_r[iplt_pkg::ZONE_LOBBY_FLOOR_LSB +: 8];

	assign doors_ok = lift_stat.landing_doors_closed &
		(swing | lift_stat.car_doors_closed);
	assign idle = ~lift_stat.calls_pending & ~lift_stat.car_pref & doors_ok;
	assign park_inh = lift_stat.car_pref | lift_stat.maintenance |
		lift_stat.guest_pending | lift_stat.prio_pending |
		lift_stat.load_hold;
	assign light_hold = lift_stat.car_pref | lift_stat.guest_pending |
		lift_stat.prio_pending | lift_stat.special_op;

	// Seconds tick; shorten TICK_CYCLES in simulation
	always_comb begin
		tick = (tick_cnt_r == TICK_LAST);
		tick_cnt_nxt = tick ? '0 : tick_cnt_r + TW'(1);
	end

	// delay counters clear on idle loss, saturate at the top
	always_comb begin
		park_cnt_nxt = park_cnt_r;
		light_cnt_nxt = light_cnt_r;
		if (!idle || park_inh)
			park_cnt_nxt = 16'h0000;
		else if (tick && park_cnt_r != 16'hffff)
			park_cnt_nxt = park_cnt_r + 16'h0001;
		if (!idle || light_hold)
			light_cnt_nxt = 16'h0000;
		else if (tick && light_cnt_r != 16'hffff)
			light_cnt_nxt = light_cnt_r + 16'h0001;
	end

	// zone middles after the lobby reservation
	always_comb begin
		zones = (team > lobby_cars) ? team - lobby_cars : 4'h0;
		zk = my_idx - lobby_cars;
		zone_num = 13'({zk, 1'b1}) * 13'(floors);
		zone_den = {zones, 1'b0};
		if (my_idx < lobby_cars || zones == 4'h0 || zk >= zones)
			zone_dest = lobby_floor;
		else
			zone_dest = 8'(zone_num / 13'(zone_den));
	end

	// Week slot guard; out of range slots do not learn
	assign slot_ok = (week_slot < 8'(SLOTS));
	assign slot = slot_ok ? SW'(week_slot) : '0;

	// majority vote of demanded floors per week slot
	always_comb begin
		lrn_we = demand_stb & slot_ok;
		lrn_idx = slot;
		lrn_cand_nxt = lrn_cand[slot];
		lrn_cnt_nxt = lrn_cnt[slot];
		if (lrn_cnt[slot] == 4'h0) begin
			lrn_cand_nxt = demand_floor;
			lrn_cnt_nxt = 4'h1;
		end else if (lrn_cand[slot] == demand_floor) begin
			if (lrn_cnt[slot] != 4'hf)
				lrn_cnt_nxt = lrn_cnt[slot] + 4'h1;
		end else begin
			lrn_cnt_nxt = lrn_cnt[slot] - 4'h1;
		end
	end

	always_comb begin
		dest_off = 1'b0;
		dest_sel = cur_floor;
		unique case (strat)
			iplt_pkg::STRAT_ZONE: dest_sel = zone_dest;
			iplt_pkg::STRAT_LEARN: begin
				if (slot_ok && lrn_cnt[slot] != 4'h0)
					dest_sel = lrn_cand[slot];
				else
					dest_off = 1'b1;
			end
			default: begin
				dest_off = (park_floor_cfg_r == iplt_pkg::FLOOR_OFF);
				dest_sel = dest_off ? cur_floor : park_floor_cfg_r;
			end
		endcase
	end

	// delay reached while idle and not inhibited
	assign park_due = (park_delay_r != 16'h0000) && idle && !park_inh &&
		(park_cnt_r >= park_delay_r);

	// Parking sequence
	always_comb begin
		park_st_nxt = park_st_r;
		dest_nxt = dest_r;
		trip_req_nxt = 1'b0;
		unique case (park_st_r)
			iplt_pkg::P_WAIT: begin
				if (park_due) begin
					dest_nxt = dest_sel;
					if (dest_off) begin
						park_st_nxt = iplt_pkg::P_PARKED;
					end else begin
						trip_req_nxt = 1'b1;
						park_st_nxt = iplt_pkg::P_TRIP;
					end
				end
			end
			iplt_pkg::P_TRIP: begin
				if (!idle || park_inh)
					park_st_nxt = iplt_pkg::P_WAIT;
				else if (arrived)
					park_st_nxt = iplt_pkg::P_PARKED;
			end
			iplt_pkg::P_PARKED: begin
				if (!idle || park_inh)
					park_st_nxt = iplt_pkg::P_WAIT;
			end
			default: park_st_nxt = iplt_pkg::P_WAIT;
		endcase
	end

	// two acknowledge messages per parking, aborted on departure
	always_comb begin
		ack_st_nxt = ack_st_r;
		unique case (ack_st_r)
			iplt_pkg::A_IDLE: begin
				if (park_st_r != iplt_pkg::P_PARKED &&
					park_st_nxt == iplt_pkg::P_PARKED)
					ack_st_nxt = iplt_pkg::A_CAR;
			end
			iplt_pkg::A_CAR: begin
				if (park_st_r != iplt_pkg::P_PARKED)
					ack_st_nxt = iplt_pkg::A_IDLE;
				else if (ack_ready)
					ack_st_nxt = iplt_pkg::A_SHAFT;
			end
			iplt_pkg::A_SHAFT: begin
				if (park_st_r != iplt_pkg::P_PARKED || ack_ready)
					ack_st_nxt = iplt_pkg::A_IDLE;
			end
			default: ack_st_nxt = iplt_pkg::A_IDLE;
		endcase
	end

	// light off after delay, standby forces off at once
	assign light_off_nxt = lift_stat.standby ||
		(light_delay_r != 16'h0000 && idle && !light_hold &&
		light_cnt_r >= light_delay_r);

	// State registers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r <= iplt_pkg::CTRL_RST;
			park_delay_r <= iplt_pkg::PARK_DELAY_RST;
			park_floor_cfg_r <= iplt_pkg::PARK_FLOOR_RST;
			park_offs_r <= iplt_pkg::PARK_OFFS_RST;
			light_delay_r <= iplt_pkg::LIGHT_DELAY_RST;
			zone_r <= iplt_pkg::ZONE_RST;
			rdata_r <= 32'h00000000;
			tick_cnt_r <= '0;
			park_cnt_r <= 16'h0000;
			light_cnt_r <= 16'h0000;
			park_st_r <= iplt_pkg::P_WAIT;
			ack_st_r <= iplt_pkg::A_IDLE;
			dest_r <= 8'h00;
			trip_req_r <= 1'b0;
			light_off_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			park_delay_r <= park_delay_nxt;
			park_floor_cfg_r <= park_floor_cfg_nxt;
			park_offs_r <= park_offs_nxt;
			light_delay_r <= light_delay_nxt;
			zone_r <= zone_nxt;
			rdata_r <= rdata_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			park_cnt_r <= park_cnt_nxt;
			light_cnt_r <= light_cnt_nxt;
			park_st_r <= park_st_nxt;
			ack_st_r <= ack_st_nxt;
			dest_r <= dest_nxt;
			trip_req_r <= trip_req_nxt;
			light_off_r <= light_off_nxt;
		end
	end

	// Learning table; cleared by reset so stale votes never steer parking
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < SLOTS; i++) begin
				lrn_cand[i] <= 8'h00;
				lrn_cnt[i] <= 4'h0;
			end
		end else if (lrn_we) begin
			lrn_cand[lrn_idx] <= lrn_cand_nxt;
			lrn_cnt[lrn_idx] <= lrn_cnt_nxt;
		end
	end

	// Outputs
	assign reg_rdata = rdata_r;
	assign trip_req = trip_req_r;
	assign trip.floor = dest_r;
	assign trip.offset_mm = (strat == iplt_pkg::STRAT_SIMPLE) ?
		park_offs_r : 16'h0000;
	assign ack_valid = (ack_st_r != iplt_pkg::A_IDLE);
	assign ack.to_shaft = (ack_st_r == iplt_pkg::A_SHAFT);
	assign ack.floor = dest_r;
	assign light_off = light_off_r;
	assign parked = (park_st_r == iplt_pkg::P_PARKED);
endmodule

// >>> dv/iplt_properties.sv
// Port checker of parking, acknowledge and light-off timing
`timescale 1ns/100ps
module iplt_chk (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input iplt_pkg::iplt_status_t lift_stat,
	input wire logic trip_req,
	input iplt_pkg::iplt_trip_t trip,
	input wire logic ack_valid,
	input wire logic ack_ready,
	input iplt_pkg::iplt_ack_t ack,
	input wire logic light_off,
	input wire logic parked
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Blockers seen at the pins; three cycles cover the counter clear lag
	wire logic inhib = lift_stat.car_pref | lift_stat.maintenance
		| lift_stat.guest_pending | lift_stat.prio_pending
		| lift_stat.load_hold;
	wire logic lhold = lift_stat.car_pref | lift_stat.guest_pending
		| lift_stat.prio_pending | lift_stat.special_op;
	wire logic busy = lift_stat.calls_pending
		| !lift_stat.landing_doors_closed;
	sequence busy3;
		busy[*3];
	endsequence
	sequence inhib3;
		inhib[*3];
	endsequence
	sequence car_taken;
		ack_valid && ack_ready && !ack.to_shaft ##1 parked;
	endsequence
	chk_trip_pulse: assert property (
		trip_req |=> !trip_req && !parked)
		else $error("trip request not a lone pulse");
	chk_trip_idle: assert property (busy3 |=> !trip_req)
		else $error("trip while not idle");
	chk_trip_inhib: assert property (inhib3 |=> !trip_req)
		else $error("trip while inhibited");
	chk_ack_first: assert property ($rose(ack_valid) |->
		$rose(parked) && !ack.to_shaft && ack.floor == trip.floor)
		else $error("first acknowledge wrong");
	chk_ack_second: assert property (car_taken |->
		ack_valid && ack.to_shaft && $stable(ack.floor))
		else $error("shaft acknowledge missing");
	chk_ack_hold: assert property (ack_valid && !ack_ready ##1 parked
		|-> ack_valid && $stable(ack))
		else $error("acknowledge dropped while stalled");
	chk_park_drop: assert property (
		parked && (busy || inhib) |=> !parked)
		else $error("parked kept after idle lost");
	chk_standby_dark: assert property (
		lift_stat.standby[*2] |-> light_off)
		else $error("light on in standby");
	chk_light_hold: assert property (
		(lhold && !lift_stat.standby)[*3] |=> !light_off)
		else $error("light off under hold");
endmodule
bind iplt_top iplt_chk chk_u (.ref_clk, .sys_rst, .lift_stat, .trip_req,
	.trip, .ack_valid, .ack_ready, .ack, .light_off, .parked);

// >>> dv/iplt_far.sv
// Drive sequencing and bus node model facing the block
`timescale 1ns/100ps
module iplt_far (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic trip_req,
	output logic arrived,
	output logic ack_ready
);
	logic [3:0] run_r;
	// Trip lasts 3 or 9 cycles; slow bus node refuses every other cycle
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_r <= 4'h0;
			arrived <= 1'b0;
			ack_ready <= 1'b0;
		end else begin
			ack_ready <= !slow || !ack_ready;
			arrived <= run_r == 4'h1;
			if (trip_req)
				run_r <= slow ? 4'h9 : 4'h3;
			else if (run_r != 4'h0)
				run_r <= run_r - 4'h1;
		end
	end
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the idle parking light timer
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
	err_total++; $display("BAD %0t got %h want %h", $time, a, e); end end
module testbench;
	localparam logic [9:0] IDLE = 10'h003;
	localparam logic [9:0] BUSY = 10'h200;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	iplt_pkg::iplt_status_t lift_stat = BUSY;
	logic [7:0] cur_floor = 8'h03;
	logic [7:0] week_slot = 8'h04;
	logic demand_stb = 1'b0;
	logic [7:0] demand_floor = 8'h07;
	logic arrived, trip_req, ack_valid, ack_ready, light_off, parked;
	logic slow = 1'b0;
	iplt_pkg::iplt_trip_t trip, trip_q;
	iplt_pkg::iplt_ack_t ack;
	iplt_pkg::iplt_ack_t acks[$];
	logic [3:0] trip_cnt = 4'h0;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	iplt_top #(.TICK_CYCLES(10)) dut_u (.ref_clk, .sys_rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lift_stat, .cur_floor,
		.week_slot, .demand_stb, .demand_floor, .arrived, .trip_req, .trip,
		.ack_valid, .ack_ready, .ack, .light_off, .parked);
	iplt_far far_u (.ref_clk, .sys_rst, .slow, .trip_req, .arrived,
		.ack_ready);
	always #5 ref_clk = ~ref_clk;
	// Record trips and accepted bus messages; cut a hang short
	always @(posedge ref_clk) begin
		cyc++;
		if (trip_req === 1'b1) begin
			trip_cnt <= trip_cnt + 4'h1;
			trip_q <= trip;
		end
		if (ack_valid === 1'b1 && ack_ready === 1'b1)
			acks.push_back(ack);
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	task summarize();
		if (err_total == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		`CHK(reg_rdata, e)
	endtask
	// Idle the car, await parking, judge trip and both acknowledges
	task park(input logic [9:0] st, input logic [7:0] fl, input logic tr,
		input logic [15:0] off, input logic pre);
		int i;
		@(posedge ref_clk);
		acks.delete();
		trip_cnt <= 4'h0;
		if (pre) begin
			lift_stat <= st;
			repeat (15) @(posedge ref_clk);
			lift_stat <= BUSY;
			repeat (2) @(posedge ref_clk);
		end
		lift_stat <= st;
		for (i = 0; i < 400 && parked !== 1'b1; i++)
			@(negedge ref_clk);
		if (pre)
			`CHK(i > 18, 1'b1);
		repeat (12) @(negedge ref_clk);
		`CHK(parked, 1'b1);
		`CHK(trip_cnt, {3'h0, tr});
		if (tr)
			`CHK(trip_q, {fl, off});
		`CHK(acks.size(), 2);
		`CHK(acks[0], {1'b0, fl});
		`CHK(acks[1], {1'b1, fl});
		// Status shows idle, parked and the held destination
		rd(iplt_pkg::REG_STATUS, {16'h0, fl, 8'h03});
		@(posedge ref_clk);
		lift_stat <= BUSY;
		repeat (3) @(negedge ref_clk);
		`CHK(parked, 1'b0);
	endtask
	task t_regs();
		rd(iplt_pkg::REG_CTRL, 32'h0);
		rd(iplt_pkg::REG_PARK_DELAY, 32'h3c);
		rd(iplt_pkg::REG_PARK_FLOOR, 32'hff);
		rd(iplt_pkg::REG_LIGHT_DELAY, 32'hb4);
		wr(iplt_pkg::REG_STATUS, 32'hffff);
		rd(iplt_pkg::REG_STATUS, 32'h0);
		rd(8'h1c, 32'h0);
	endtask
	// each blocker, plus open car door with automatic doors
	task t_inhib();
		trip_cnt <= 4'h0;
		for (int b = 1; b < 10; b++) begin
			if (b == 2 || b == 3)
				continue;
			@(posedge ref_clk);
			lift_stat <= IDLE ^ (10'h001 << b);
			repeat (50) @(negedge ref_clk);
			`CHK(parked, 1'b0);
		end
		`CHK(trip_cnt, 4'h0);
	endtask
	// middle of zone, then a car held at the lobby
	task t_zone();
		wr(iplt_pkg::REG_CTRL, 32'h1);
		wr(iplt_pkg::REG_ZONE, 32'h0008102);
		park(IDLE, 8'h06, 1'b1, 16'h0, 1'b0);
		wr(iplt_pkg::REG_ZONE, 32'h0908012);
		park(IDLE, 8'h09, 1'b1, 16'h0, 1'b0);
	endtask
	task t_learn();
		wr(iplt_pkg::REG_CTRL, 32'h2);
		repeat (3) begin
			@(posedge ref_clk);
			demand_stb <= 1'b1;
			@(posedge ref_clk);
			demand_stb <= 1'b0;
		end
		park(IDLE, 8'h07, 1'b1, 16'h0, 1'b0);
	endtask
	// delay with swing doors open in the car, hold and standby
	task t_light();
		int i;
		// swing doors: car door state is ignored, landing doors decide
		wr(iplt_pkg::REG_CTRL, 32'h4);
		wr(iplt_pkg::REG_LIGHT_DELAY, 32'h2);
		lift_stat <= 10'h009;
		repeat (60) @(negedge ref_clk);
		`CHK(light_off, 1'b0);
		@(posedge ref_clk);
		lift_stat <= 10'h00d;
		repeat (2) @(negedge ref_clk);
		`CHK(light_off, 1'b1);
		@(posedge ref_clk);
		lift_stat <= 10'h001;
		repeat (2) @(negedge ref_clk);
		`CHK(light_off, 1'b0);
		for (i = 0; i < 100 && light_off !== 1'b1; i++)
			@(negedge ref_clk);
		`CHK(light_off, 1'b1);
		`CHK(i > 8, 1'b1);
		@(posedge ref_clk);
		lift_stat <= BUSY;
		repeat (2) @(negedge ref_clk);
		`CHK(light_off, 1'b0);
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_regs();
		wr(iplt_pkg::REG_PARK_DELAY, 32'h3);
		wr(iplt_pkg::REG_PARK_FLOOR, 32'h5);
		wr(iplt_pkg::REG_PARK_OFFS, 32'hfff0);
		park(IDLE, 8'h05, 1'b1, 16'hfff0, 1'b1);
		t_inhib();
		wr(iplt_pkg::REG_PARK_FLOOR, 32'hff);
		park(IDLE, 8'h03, 1'b0, 16'h0, 1'b0);
		wr(iplt_pkg::REG_CTRL, 32'h4);
		wr(iplt_pkg::REG_PARK_FLOOR, 32'h2);
		slow <= 1'b1;
		park(10'h001, 8'h02, 1'b1, 16'hfff0, 1'b0);
		slow <= 1'b0;
		t_zone();
		t_learn();
		t_light();
		summarize();
	end
endmodule
